/* src/rdc_top.v */
// regulator and dim control top: registers, two converter sequencers, dim mux
// assumes host register port is a simple synchronous write/read strobe port
// Function
// - aux level select 3-bit code picks one of eight output voltages.
// - level select resets to the 5 V code.
// - control bit 0 enables the aux regulator.
// - both converters ramp their reference softly at start.
// - output held low for 15 ms shuts that converter down.
// - after 120 ms cool-down the converter restarts by itself.
// - excessive on-state drain-source voltage latches the converter off.
// - aux latched fault sets the aux fault status flag.
// - unmasked aux fault flag drives the active-low interrupt.
// - compensation ramp on only for 15 V and 24 V settings.
// - emitter driver switches only while its enable bit is set.
// - dim input low routes zero-current level to dim node unless the dac select bit is set.
// - dim input high routes analog dim level to dim node unless the dac select bit is set.
// - dac select bit routes internal 7-bit DAC to dim node.
// - DAC output is reference times code plus one over 128.
`timescale 1ns/1ps
`include "rdc_regs.vh"

module rdc_top #(
    parameter SHORT_CYC = `RDC_SHORT_CYC,
    parameter COOL_CYC  = `RDC_COOL_CYC
) (
    input  wire       clk_sys,          // system clock
    input  wire       rst_b,            // sync reset, active low
    input  wire [7:0] reg_addr,         // register offset
    input  wire       reg_wr,           // write strobe
    input  wire [7:0] reg_wdata,        // write data
    input  wire       reg_rd,           // read strobe
    output reg  [7:0] reg_rdata,        // read data, one cycle after strobe
    input  wire       aux_under_volt,   // aux output well below target
    input  wire       aux_vds_over,     // aux switch excessive drain-source voltage
    input  wire       emit_under_volt,  // emitter output well below target
    input  wire       emit_vds_over,    // emitter switch excessive drain-source voltage
    input  wire       pwm_dim,          // pulse-width dimming input
    output reg  [2:0] aux_level_select, // level select to aux regulator
    output wire       aux_regulator_enable, // aux regulator switching allowed
    output wire [7:0] aux_soft_ramp,    // aux soft-start reference
    output reg        aux_comp_ramp_en, // compensation ramp enable
    output wire       emitter_run,      // emitter driver switching allowed
    output wire [7:0] emit_soft_ramp,   // emitter soft-start reference
    output reg  [1:0] dim_mux_sel,      // 0 zero level, 1 analog dim, 2 dac
    output reg  [6:0] internal_dac_code_out, // code applied to dac
    output wire       interrupt_out_n   // interrupt, active low
);

    // ****************************************************************
    // mux select encodings
    // ****************************************************************
    localparam MUX_ZERO   = 2'd0;
    localparam MUX_ANALOG = 2'd1;
    localparam MUX_DAC    = 2'd2;

    // ****************************************************************
    // registers
    // ****************************************************************
    reg  [7:0] main_control_reg;
    reg  [7:0] aux_level_cfg_reg;
    reg  [7:0] int_dim_dac_reg;
    reg  [7:0] pos_int_mask_reg;
    reg        aux_fault_flag_reg;
    reg        emit_fault_flag_reg;
    reg        aux_latched_d_reg;
    reg        emit_latched_d_reg;

    wire       aux_latched;
    wire       emit_latched;
    wire       aux_run;
    wire       aux_cooling;
    wire       emit_cooling;
    wire       aux_fault_set;
    wire       emit_fault_set;
    wire       stat_clr;
    wire [7:0] pos_status;

    function [7:0] rd_mux;
        input [7:0] addr;
        input [7:0] ctl;
        input [7:0] lvl;
        input [7:0] dac;
        input [7:0] sts;
        input [7:0] msk;
        begin
            case (addr)
                `RDC_OFS_MAIN_CONTROL:  rd_mux = ctl;
                `RDC_OFS_AUX_LEVEL_CFG: rd_mux = lvl;
                `RDC_OFS_INT_DIM_DAC:   rd_mux = dac;
                `RDC_OFS_POS_STATUS:    rd_mux = sts;
                `RDC_OFS_POS_INT_MASK:  rd_mux = msk;
                default:                rd_mux = 8'h00;
            endcase
        end
    endfunction

    assign pos_status = {4'h0, aux_cooling, emit_cooling,
                         emit_fault_flag_reg, aux_fault_flag_reg};

    // rising edge of latch state is the event; a steady latch does not re-set after clear
    assign aux_fault_set  = aux_latched && !aux_latched_d_reg;
    assign emit_fault_set = emit_latched && !emit_latched_d_reg;
    assign stat_clr       = reg_wr && (reg_addr == `RDC_OFS_POS_STATUS);

    // ****************************************************************
    // register writes
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            main_control_reg    <= `RDC_RST_MAIN_CONTROL;
            aux_level_cfg_reg   <= `RDC_RST_AUX_LEVEL_CFG;
            int_dim_dac_reg     <= `RDC_RST_INT_DIM_DAC;
            pos_int_mask_reg    <= `RDC_RST_POS_INT_MASK;
            aux_fault_flag_reg  <= 1'b0;
            emit_fault_flag_reg <= 1'b0;
            aux_latched_d_reg   <= 1'b0;
            emit_latched_d_reg  <= 1'b0;
            reg_rdata           <= 8'h00;
        end else begin
            aux_latched_d_reg  <= aux_latched;
            emit_latched_d_reg <= emit_latched;
            if (reg_wr) begin
                case (reg_addr)
                    `RDC_OFS_MAIN_CONTROL:  main_control_reg <= {6'h00, reg_wdata[1:0]};
                    // a write while the aux regulator runs is a host fault; kept as written
                    `RDC_OFS_AUX_LEVEL_CFG: aux_level_cfg_reg <= {5'h00, reg_wdata[2:0]};
                    `RDC_OFS_INT_DIM_DAC:   int_dim_dac_reg <= reg_wdata;
                    `RDC_OFS_POS_INT_MASK:  pos_int_mask_reg <= {6'h00, reg_wdata[1:0]};
                    default: begin
                    end
                endcase
            end
            // write one to clear; a new fault in the same cycle wins
            if (aux_fault_set) begin
                aux_fault_flag_reg <= 1'b1;
            end else if (stat_clr && reg_wdata[`RDC_BIT_AUX_FAULT]) begin
                aux_fault_flag_reg <= 1'b0;
            end
            if (emit_fault_set) begin
                emit_fault_flag_reg <= 1'b1;
            end else if (stat_clr && reg_wdata[`RDC_BIT_EMIT_FAULT]) begin
                emit_fault_flag_reg <= 1'b0;
            end
            if (reg_rd) begin
                reg_rdata <= rd_mux(reg_addr, main_control_reg, aux_level_cfg_reg,
                                    int_dim_dac_reg, pos_status, pos_int_mask_reg);
            end
        end
    end

    // ****************************************************************
    // converters
    // ****************************************************************
    rdc_conv_ctl #(
        .SHORT_CYC (SHORT_CYC),
        .COOL_CYC  (COOL_CYC),
        .STEP_CYC  (`RDC_RAMP_STEP_CYC)
    ) u_aux (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .enable     (main_control_reg[`RDC_BIT_AUX_ON]),
        .under_volt (aux_under_volt),
        .vds_over   (aux_vds_over),
        .run        (aux_run),
        .ramp_reg   (aux_soft_ramp),
        .latched    (aux_latched),
        .cooling    (aux_cooling)
    );

    rdc_conv_ctl #(
        .SHORT_CYC (SHORT_CYC),
        .COOL_CYC  (COOL_CYC),
        .STEP_CYC  (`RDC_RAMP_STEP_CYC)
    ) u_emit (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .enable     (main_control_reg[`RDC_BIT_EMIT_EN]),
        .under_volt (emit_under_volt),
        .vds_over   (emit_vds_over),
        .run        (emitter_run),
        .ramp_reg   (emit_soft_ramp),
        .latched    (emit_latched),
        .cooling    (emit_cooling)
    );

    assign aux_regulator_enable = aux_run;

    // mask bit one means masked
    assign interrupt_out_n = !((aux_fault_flag_reg && !pos_int_mask_reg[`RDC_BIT_AUX_FAULT]) ||
                               (emit_fault_flag_reg && !pos_int_mask_reg[`RDC_BIT_EMIT_FAULT]));

    // ****************************************************************
    // level, compensation ramp and dim mux outputs
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            aux_level_select      <= 3'h2;
            aux_comp_ramp_en      <= 1'b0;
            dim_mux_sel           <= MUX_ZERO;
            internal_dac_code_out <= 7'h00;
        end else begin
            aux_level_select <= aux_level_cfg_reg[2:0];
            aux_comp_ramp_en <= (aux_level_cfg_reg[2:0] == `RDC_LVL_15V) ||
                                (aux_level_cfg_reg[2:0] == `RDC_LVL_24V);
            // dac gives vref*(code+1)/128; analog side adds the one
            internal_dac_code_out <= int_dim_dac_reg[6:0];
            if (int_dim_dac_reg[`RDC_BIT_DAC_SEL]) begin
                dim_mux_sel <= MUX_DAC;
            end else if (pwm_dim) begin
                dim_mux_sel <= MUX_ANALOG;
            end else begin
                dim_mux_sel <= MUX_ZERO;
            end
        end
    end

endmodule

/* src/rdc_regs.vh */
// register offsets, field positions, reset values and timing counts
// assumes a 250 MHz system clock; included by rdc_top.v and rdc_conv_ctl.v
`ifndef RDC_REGS_VH
`define RDC_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define RDC_OFS_MAIN_CONTROL    8'h04
`define RDC_OFS_AUX_LEVEL_CFG   8'h6E
`define RDC_OFS_INT_DIM_DAC     8'h6F
`define RDC_OFS_POS_STATUS      8'h70
`define RDC_OFS_POS_INT_MASK    8'h71

// ****************************************************************
// fields
// ****************************************************************
`define RDC_BIT_AUX_ON          0
`define RDC_BIT_EMIT_EN         1
`define RDC_BIT_DAC_SEL         7
`define RDC_BIT_AUX_FAULT       0
`define RDC_BIT_EMIT_FAULT      1

// ****************************************************************
// reset values
// ****************************************************************
`define RDC_RST_MAIN_CONTROL    8'h00
`define RDC_RST_AUX_LEVEL_CFG   8'h02
`define RDC_RST_INT_DIM_DAC     8'h00
`define RDC_RST_POS_INT_MASK    8'h00

// ****************************************************************
// level select codes needing compensation ramp
// ****************************************************************
`define RDC_LVL_15V             3'h3
`define RDC_LVL_24V             3'h7

// ****************************************************************
// timing
// ****************************************************************
`define RDC_CLK_HZ              250000000
`define RDC_T_SHORT_MS          15
`define RDC_T_COOL_MS           120
`define RDC_SHORT_CYC           ((`RDC_CLK_HZ / 1000) * `RDC_T_SHORT_MS)
`define RDC_COOL_CYC            ((`RDC_CLK_HZ / 1000) * `RDC_T_COOL_MS)
`define RDC_RAMP_STEP_CYC       16

`endif

/* src/rdc_conv_ctl.v */
// one converter sequencer: soft start, short-circuit shutdown and restart, latch-off
// assumes synchronous fault inputs from the analog comparators
`timescale 1ns/1ps
`include "rdc_regs.vh"

module rdc_conv_ctl #(
    parameter SHORT_CYC = `RDC_SHORT_CYC,
    parameter COOL_CYC  = `RDC_COOL_CYC,
    parameter STEP_CYC  = `RDC_RAMP_STEP_CYC
) (
    input  wire       clk_sys,     // system clock
    input  wire       rst_b,       // sync reset, active low
    input  wire       enable,      // software enable level
    input  wire       under_volt,  // output well below target
    input  wire       vds_over,    // excessive on-state drain-source voltage
    output wire       run,         // converter allowed to switch
    output reg  [7:0] ramp_reg,    // soft-start reference level
    output wire       latched,     // latched off by severe fault
    output wire       cooling      // in short-circuit cool-down
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam ST_OFF   = 3'd0;
    localparam ST_RAMP  = 3'd1;
    localparam ST_ON    = 3'd2;
    localparam ST_COOL  = 3'd3;
    localparam ST_LATCH = 3'd4;

    reg [2:0]  state_reg;
    reg [31:0] cnt_reg;
    reg [31:0] step_reg;

    assign run     = (state_reg == ST_RAMP) || (state_reg == ST_ON);
    assign latched = (state_reg == ST_LATCH);
    assign cooling = (state_reg == ST_COOL);

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg <= ST_OFF;
            cnt_reg   <= 32'h0000_0000;
            step_reg  <= 32'h0000_0000;
            ramp_reg  <= 8'h00;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    cnt_reg  <= 32'h0000_0000;
                    ramp_reg <= 8'h00;
                    if (enable) begin
                        state_reg <= ST_RAMP;
                    end
                end
                ST_RAMP, ST_ON: begin
                    if (!enable) begin
                        state_reg <= ST_OFF;
                    end else if (vds_over) begin
                        state_reg <= ST_LATCH;
                    end else if (under_volt && state_reg == ST_ON &&
                                 cnt_reg == SHORT_CYC - 1) begin
                        state_reg <= ST_COOL;
                        cnt_reg   <= 32'h0000_0000;
                    end else begin
                        // under-volt only counted after ramp, when output should be up
                        if (under_volt && state_reg == ST_ON) begin
                            cnt_reg <= cnt_reg + 32'h0000_0001;
                        end else begin
                            cnt_reg <= 32'h0000_0000;
                        end
                        if (state_reg == ST_RAMP) begin
                            if (step_reg == STEP_CYC - 1) begin
                                step_reg <= 32'h0000_0000;
                                ramp_reg <= ramp_reg + 8'h01;
                                if (ramp_reg == 8'hFE) begin
                                    state_reg <= ST_ON;
                                end
                            end else begin
                                step_reg <= step_reg + 32'h0000_0001;
                            end
                        end
                    end
                end
                ST_COOL: begin
                    ramp_reg <= 8'h00;
                    if (!enable) begin
                        state_reg <= ST_OFF;
                    end else if (cnt_reg == COOL_CYC - 1) begin
                        state_reg <= ST_RAMP;
                        cnt_reg   <= 32'h0000_0000;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h0000_0001;
                    end
                end
                ST_LATCH: begin
                    ramp_reg <= 8'h00;
                    if (!enable) begin
                        state_reg <= ST_OFF;
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

endmodule

/* verif/rdc_top_assertions.sv */
// checker for rdc_top: sequencing, fault handling, interrupt and dim routing
// assumes it is bound to rdc_top and sees only its ports
`timescale 1ns/1ps
module rdc_top_assertions #(
    parameter SHORT_CYC = 20,
    parameter COOL_CYC  = 50
) (
    input wire       clk_sys,              // system clock
    input wire       rst_b,                // sync reset, active low
    input wire [7:0] reg_addr,             // register offset
    input wire       reg_wr,               // write strobe
    input wire [7:0] reg_wdata,            // write data
    input wire       aux_under_volt,       // aux output low
    input wire       aux_vds_over,         // aux severe fault
    input wire       emit_vds_over,        // emitter severe fault
    input wire       pwm_dim,              // pulse-width dim input
    input wire [2:0] aux_level_select,     // level select
    input wire       aux_regulator_enable, // aux switching allowed
    input wire [7:0] aux_soft_ramp,        // aux soft-start level
    input wire       aux_comp_ramp_en,     // compensation ramp
    input wire       emitter_run,          // emitter switching allowed
    input wire [1:0] dim_mux_sel,          // dim route
    input wire       interrupt_out_n       // interrupt, active low
);
    reg        ctl0_reg;
    reg        ctl1_reg;
    reg        lat_reg;
    reg        seen_reg;
    reg [31:0] uv_reg;
    reg [31:0] off_reg;
    wire       ctl_wr = reg_wr && reg_addr == 8'h04;
    // counters run slightly ahead of the design, so limits carry slack
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            ctl0_reg <= 1'b0;
            ctl1_reg <= 1'b0;
            lat_reg  <= 1'b0;
            seen_reg <= 1'b0;
            uv_reg   <= 32'h0000_0000;
            off_reg  <= 32'h0000_0000;
        end else begin
            if (ctl_wr) begin
                ctl0_reg <= reg_wdata[0];
                ctl1_reg <= reg_wdata[1];
            end
            if (ctl_wr && !reg_wdata[0])
                lat_reg <= 1'b0;
            else if (aux_vds_over && aux_regulator_enable)
                lat_reg <= 1'b1;
            if (aux_vds_over || emit_vds_over)
                seen_reg <= 1'b1;
            uv_reg  <= (aux_regulator_enable && aux_soft_ramp == 8'hFF && aux_under_volt) ?
                       uv_reg + 1 : 32'h0000_0000;
            off_reg <= (!aux_regulator_enable && ctl0_reg && !lat_reg) ?
                       off_reg + 1 : 32'h0000_0000;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    comp_ramp_sel_a: assert property ($stable(aux_level_select) ##1 $stable(aux_level_select)
        |-> aux_comp_ramp_en == (aux_level_select == 3'h3 || aux_level_select == 3'h7))
        else $error("compensation ramp does not match level");
    aux_on_write_a: assert property (ctl_wr && reg_wdata[0] && !ctl0_reg
        |-> ##2 aux_regulator_enable) else $error("aux not started by enable write");
    aux_off_write_a: assert property (ctl_wr && !reg_wdata[0] |-> ##2 !aux_regulator_enable)
        else $error("aux still running after disable write");
    soft_ramp_step_a: assert property (aux_regulator_enable ##1 aux_regulator_enable
        |-> aux_soft_ramp == $past(aux_soft_ramp) || aux_soft_ramp == $past(aux_soft_ramp) + 8'h01)
        else $error("soft start jumped");
    short_limit_a: assert property (uv_reg <= SHORT_CYC + 18)
        else $error("aux not shut down on sustained undervoltage");
    cool_restart_a: assert property (off_reg <= COOL_CYC + 4)
        else $error("aux not restarted after cool-down");
    latch_off_a: assert property (lat_reg |-> !aux_regulator_enable)
        else $error("aux running while latched");
    irq_cause_a: assert property (!interrupt_out_n |-> seen_reg)
        else $error("interrupt without fault");
    irq_masked_a: assert property (reg_wr && reg_addr == 8'h71 && reg_wdata[1:0] == 2'h3
        |=> interrupt_out_n) else $error("masked interrupt still active");
    emit_gate_a: assert property (emitter_run |-> ctl1_reg || $past(ctl1_reg))
        else $error("emitter running without enable");
    dim_route_a: assert property (dim_mux_sel != 2'h2 |-> dim_mux_sel == {1'b0, $past(pwm_dim)})
        else $error("dim route does not follow pwm input");
    cover property ($fell(aux_regulator_enable) && !lat_reg);
    cover property ($fell(interrupt_out_n));
    cover property (dim_mux_sel == 2'h2);
endmodule

bind rdc_top rdc_top_assertions #(.SHORT_CYC(SHORT_CYC), .COOL_CYC(COOL_CYC)) rdc_top_assertions_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .aux_under_volt(aux_under_volt), .aux_vds_over(aux_vds_over),
    .emit_vds_over(emit_vds_over), .pwm_dim(pwm_dim), .aux_level_select(aux_level_select),
    .aux_regulator_enable(aux_regulator_enable), .aux_soft_ramp(aux_soft_ramp),
    .aux_comp_ramp_en(aux_comp_ramp_en), .emitter_run(emitter_run),
    .dim_mux_sel(dim_mux_sel), .interrupt_out_n(interrupt_out_n));

/* verif/rdc_host_model.sv */
// host controller model: register strobes and the pulse-width dim level
// assumes the register port takes strobes on the rising clock edge
`timescale 1ns/1ps
module rdc_host_model (
    input  wire       clk_sys,   // system clock
    input  wire [7:0] reg_rdata, // read data
    output reg  [7:0] reg_addr,  // register offset
    output reg        reg_wr,    // write strobe
    output reg  [7:0] reg_wdata, // write data
    output reg        reg_rd,    // read strobe
    output reg        pwm_dim    // pulse-width dim level
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
        pwm_dim   = 1'b0;
    end
    // level config is only written while the aux regulator is off
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            #1 reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(posedge clk_sys);
            #1 reg_wr = 1'b0;
            reg_wdata = ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk_sys);
            #1 reg_addr = a;
            reg_rd = 1'b1;
            @(posedge clk_sys);
            #1 reg_rd = 1'b0;
            d = reg_rdata;
        end
    endtask
    // only held levels, never a fast toggle, so the dim frequency stays low
    task set_pwm(input v);
        begin
            @(posedge clk_sys);
            #1 pwm_dim = v;
        end
    endtask
endmodule

/* verif/tb_top.sv */
// self-checking bench for rdc_top, host model on the register port
// assumes shortened short-circuit and cool-down counts
`timescale 1ns/1ps
module tb_top;
    localparam SHORT = 20;
    localparam COOL  = 50;
    reg        clk_sys;
    reg        rst_b;
    reg        aux_uv;
    reg        aux_vds;
    reg        emit_vds;
    wire [7:0] reg_addr, reg_wdata, reg_rdata, aux_soft_ramp, emit_soft_ramp;
    wire       reg_wr, reg_rd, pwm_dim, aux_comp_ramp_en, aux_regulator_enable;
    wire       emitter_run, interrupt_out_n;
    wire [2:0] aux_level_select;
    wire [1:0] dim_mux_sel;
    wire [6:0] internal_dac_code_out;
    integer    fails;
    integer    checks_done;
    integer    i;
    integer    n;
    reg [7:0]  rv;
    rdc_host_model rdc_host_model_inst (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .pwm_dim(pwm_dim));
    rdc_top #(.SHORT_CYC(SHORT), .COOL_CYC(COOL)) rdc_top_inst (.clk_sys(clk_sys),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .aux_under_volt(aux_uv),
        .aux_vds_over(aux_vds), .emit_under_volt(aux_uv), .emit_vds_over(emit_vds),
        .pwm_dim(pwm_dim), .aux_level_select(aux_level_select),
        .aux_regulator_enable(aux_regulator_enable), .aux_soft_ramp(aux_soft_ramp),
        .aux_comp_ramp_en(aux_comp_ramp_en), .emitter_run(emitter_run),
        .emit_soft_ramp(emit_soft_ramp), .dim_mux_sel(dim_mux_sel),
        .internal_dac_code_out(internal_dac_code_out), .interrupt_out_n(interrupt_out_n));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("ERROR %0t ns: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        begin
            rdc_host_model_inst.rd(a, rv);
            check(rv, exp);
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge clk_sys);
            #1;
        end
    endtask
    // ramp steps every 16 cycles, so full scale takes about 4080 cycles
    task wait_ramp;
        begin
            n = 0;
            while (aux_soft_ramp !== 8'hFF && n < 5000) begin
                @(posedge clk_sys);
                #1 n = n + 1;
            end
            check({7'h00, n > 4000 && n < 4100}, 8'h01);
            repeat (20) @(posedge clk_sys);
            #1;
        end
    endtask
    task summarize;
        begin
            $display("checks %0d, mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        #200000;
        fails = fails + 1;
        $display("ERROR %0t ns: watchdog expired", $time);
        summarize;
    end
    initial begin
        rst_b = 1'b0;
        aux_uv = 1'b0;
        aux_vds = 1'b0;
        emit_vds = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (5) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        rchk(8'h04, 8'h00);
        rchk(8'h6E, 8'h02);
        check({5'h00, aux_level_select}, 8'h02);
        rdc_host_model_inst.wr(8'h20, 8'hFF);
        rchk(8'h20, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            rdc_host_model_inst.wr(8'h6E, i[7:0]);
            settle;
            check({5'h00, aux_level_select}, i[7:0]);
            check({7'h00, aux_comp_ramp_en}, (i == 3 || i == 7) ? 8'h01 : 8'h00);
        end
        rdc_host_model_inst.wr(8'h6E, 8'h02);
        settle;
        check({6'h00, dim_mux_sel}, 8'h00);
        rdc_host_model_inst.set_pwm(1'b1);
        settle;
        check({6'h00, dim_mux_sel}, 8'h01);
        rdc_host_model_inst.wr(8'h6F, 8'hAA);
        settle;
        check({6'h00, dim_mux_sel}, 8'h02);
        check({1'b0, internal_dac_code_out}, 8'h2A);
        rdc_host_model_inst.wr(8'h6F, 8'h00);
        rdc_host_model_inst.set_pwm(1'b0);
        rdc_host_model_inst.wr(8'h04, 8'h02);
        settle;
        check({7'h00, emitter_run}, 8'h01);
        check(emit_soft_ramp, 8'h00);
        repeat (20) @(posedge clk_sys);
        #1 check(emit_soft_ramp, 8'h01);
        emit_vds = 1'b1;
        @(posedge clk_sys);
        #1 emit_vds = 1'b0;
        settle;
        check({7'h00, emitter_run}, 8'h00);
        rchk(8'h70, 8'h02);
        rdc_host_model_inst.wr(8'h70, 8'h02);
        rdc_host_model_inst.wr(8'h04, 8'h00);
        settle;
        check({7'h00, emitter_run}, 8'h00);
        rdc_host_model_inst.wr(8'h04, 8'h01);
        settle;
        check({7'h00, aux_regulator_enable}, 8'h01);
        check(aux_soft_ramp, 8'h00);
        wait_ramp;
        aux_uv = 1'b1;
        n = 0;
        while (aux_regulator_enable === 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1 n = n + 1;
        end
        check({7'h00, n >= SHORT && n <= SHORT + 3}, 8'h01);
        rchk(8'h70, 8'h08);
        aux_uv = 1'b0;
        n = 2;
        while (aux_regulator_enable !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1 n = n + 1;
        end
        check({7'h00, n >= COOL && n <= COOL + 4}, 8'h01);
        wait_ramp;
        aux_vds = 1'b1;
        @(posedge clk_sys);
        #1 aux_vds = 1'b0;
        check({7'h00, aux_regulator_enable}, 8'h00);
        settle;
        check({7'h00, interrupt_out_n}, 8'h00);
        rchk(8'h70, 8'h01);
        rdc_host_model_inst.wr(8'h71, 8'h03);
        settle;
        check({7'h00, interrupt_out_n}, 8'h01);
        rdc_host_model_inst.wr(8'h71, 8'h00);
        settle;
        check({7'h00, interrupt_out_n}, 8'h00);
        rdc_host_model_inst.wr(8'h70, 8'h01);
        rchk(8'h70, 8'h00);
        check({7'h00, interrupt_out_n}, 8'h01);
        repeat (100) @(posedge clk_sys);
        #1 check({7'h00, aux_regulator_enable}, 8'h00);
        rdc_host_model_inst.wr(8'h04, 8'h00);
        rdc_host_model_inst.wr(8'h04, 8'h01);
        settle;
        check({7'h00, aux_regulator_enable}, 8'h01);
        summarize;
    end
endmodule
